// [shared/tsm_defines.svh]
// Purpose: Register offsets, field positions, reset values and sizes
// Assumes: 32-bit AHB-Lite register map, one aligned word per register
// Notes:   Definitions only; included by bare name
`ifndef TSM_DEFINES_SVH
`define TSM_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define TSM_OFF_CTRL    8'h00
`define TSM_OFF_CMD     8'h04
`define TSM_OFF_STATUS  8'h08
`define TSM_OFF_W_BASE  8'h10
`define TSM_OFF_XLO     8'h20
`define TSM_OFF_XHI     8'h24
`define TSM_OFF_V_BASE  8'h30
`define TSM_OFF_PSEL    8'h40
`define TSM_OFF_PDATA   8'h44
`define TSM_OFF_ZSEL    8'h48
`define TSM_OFF_ZDATA   8'h4c
`define TSM_OFF_TSEL    8'h50
`define TSM_OFF_TDATA   8'h54

// ****************************************
// Control register bits
// ****************************************
`define TSM_CTRL_STREAM 0
`define TSM_CTRL_MATRIX 1
`define TSM_CTRL_TABLE  2
`define TSM_CTRL_HALTED 3
`define TSM_CTRL_V2     4
`define TSM_CTRL_DIT    5
`define TSM_CTRL_WIDTH  6
`define TSM_CTRL_RESET  6'h00

// ****************************************
// Command word field positions
// ****************************************
`define TSM_F_OP        0
`define TSM_F_SIZE      4
`define TSM_F_TILE      7
`define TSM_F_RS        11
`define TSM_F_OFF       13
`define TSM_F_VERT      17
`define TSM_F_PG        18
`define TSM_F_SEL       21

// ****************************************
// Sizes and reset values
// ****************************************
`define TSM_VL          128
`define TSM_PL          16
`define TSM_ZA_ROWS     16
`define TSM_TABLE_BITS  512
`define TSM_WIDE_BITS   64
`define TSM_SIZE_MAX    3'h4
`define TSM_WORD_RESET  32'h0000_0000
`define TSM_EXEC_CYCLES 1

`endif

// [shared/tsm_pkg.sv]
// Purpose: Types shared by the slice, table and predicate engine
// Assumes: Constants live in tsm_defines.svh
// Notes:   Command and status encodings only
package tsm_pkg;

    // Command opcodes carried in the command word
    typedef enum logic [3:0] {
        OP_NONE        = 4'h0,
        OP_SLICE_MOVE  = 4'h1,
        OP_TABLE_READ  = 4'h2,
        OP_TABLE_WRITE = 4'h3,
        OP_EXPAND_ONE  = 4'h4,
        OP_EXPAND_PAIR = 4'h5,
        OP_ALL_ACTIVE  = 4'h6
    } tsm_op_type;

    // Outcome of the last command
    typedef enum logic [1:0] {
        ST_OK        = 2'h0,
        ST_UNDEFINED = 2'h1,
        ST_TRAP      = 2'h2,
        ST_ILLEGAL   = 2'h3
    } tsm_status_type;

endpackage : tsm_pkg

// [rtl/tsm_core.sv]
// Purpose: Tile slice move, table move and counter predicate engine
// Assumes: 128-bit vectors, AHB-Lite single word transfers, one clock
// Notes:   Commands execute at the edge that ends the command write
//
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "tsm_defines.svh"

module tsm_core
    import tsm_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp
);

    // ****************************************
    // Helper functions
    // ****************************************

    // Predicate bit that governs a byte lane for a given element size
    function automatic logic pred_at(input logic [15:0] p, input int byte_idx,
                                     input logic [2:0] code);
        return p[4'((byte_idx >> code) << code)];
    endfunction : pred_at

    // Pattern with only the lowest bit of each element set
    function automatic logic [15:0] low_pattern(input logic [1:0] code);
        logic [15:0] pat;
        pat = '0;
        for (int i = 0; i < `TSM_PL; i++) begin
            if ((i % (1 << code)) == 0) begin
                pat[i] = 1'b1;
            end
        end
        return pat;
    endfunction : low_pattern

    // Counter predicate to a mask four predicates wide
    function automatic logic [63:0] counter_to_mask(input logic [15:0] pc);
        logic [63:0] m;
        int          code;
        int          count;
        m     = '0;
        code  = -1;
        count = 0;
        if (pc[0]) begin
            code = 0;
        end else if (pc[1]) begin
            code = 1;
        end else if (pc[2]) begin
            code = 2;
        end else if (pc[3]) begin
            code = 3;
        end
        if (code >= 0) begin
            count = int'(pc[14:0]) >> (code + 1);
            for (int e = 0; e < `TSM_WIDE_BITS; e++) begin
                if ((e % (1 << code)) == 0) begin
                    m[e] = pc[15] ? ((e >> code) >= count) : ((e >> code) < count);
                end
            end
        end
        return m;
    endfunction : counter_to_mask

    // All-active counter encoding: count above the size marker
    function automatic logic [15:0] all_active_code(input logic [1:0] code);
        logic [15:0] cnt;
        cnt = 16'h0010 >> code;
        return (cnt << (3'(code) + 3'h1)) | (16'h0001 << code);
    endfunction : all_active_code

    // ****************************************
    // Storage
    // ****************************************
    logic [`TSM_CTRL_WIDTH-1:0]   ctrl_q;
    logic [31:0]                  w_q [4];
    logic [63:0]                  x_q;
    logic [`TSM_VL-1:0]           vec_q;
    logic [15:0]                  pred_q [16];
    logic [`TSM_VL-1:0]           za_q [`TSM_ZA_ROWS];
    logic [`TSM_VL-1:0]           za_d [`TSM_ZA_ROWS];
    logic [`TSM_TABLE_BITS-1:0]   zt_q;
    logic [3:0]                   psel_q;
    logic [5:0]                   zsel_q;
    logic [3:0]                   tsel_q;
    logic [31:0]                  last_cmd_q;
    tsm_status_type               status_q;
    logic [15:0]                  done_cnt_q;

    // ****************************************
    // AHB-Lite slave front end
    // ****************************************
    logic        addr_phase;
    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    logic [31:0] rd_val;

    assign addr_phase = hsel && htrans[1] && hready;

    // Write address held for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= addr_phase && hwrite;
            wr_addr_q <= haddr[7:0];
        end
    end

    // Zero wait states, always OKAY; hsize ignored, whole words only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= `TSM_WORD_RESET;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= (addr_phase && !hwrite) ? rd_val : `TSM_WORD_RESET;
        end
    end

    // Read mux; unmapped offsets read as zero
    always_comb begin
        rd_val = `TSM_WORD_RESET;
        case (haddr[7:0])
            `TSM_OFF_CTRL:   rd_val = {26'h0, ctrl_q};
            `TSM_OFF_CMD:    rd_val = last_cmd_q;
            `TSM_OFF_STATUS: rd_val = {done_cnt_q, 14'h0, status_q};
            `TSM_OFF_XLO:    rd_val = x_q[31:0];
            `TSM_OFF_XHI:    rd_val = x_q[63:32];
            `TSM_OFF_PSEL:   rd_val = {28'h0, psel_q};
            `TSM_OFF_PDATA:  rd_val = {16'h0, pred_q[psel_q]};
            `TSM_OFF_ZSEL:   rd_val = {26'h0, zsel_q};
            `TSM_OFF_ZDATA:  rd_val = za_q[zsel_q[5:2]][zsel_q[1:0]*32 +: 32];
            `TSM_OFF_TSEL:   rd_val = {28'h0, tsel_q};
            `TSM_OFF_TDATA:  rd_val = zt_q[tsel_q*32 +: 32];
            default: begin
                if (haddr[7:4] == `TSM_OFF_W_BASE >> 4) begin
                    rd_val = w_q[haddr[3:2]];
                end else if (haddr[7:4] == `TSM_OFF_V_BASE >> 4) begin
                    rd_val = vec_q[haddr[3:2]*32 +: 32];
                end
            end
        endcase
    end

    // ****************************************
    // Command decode
    // ****************************************
    logic           go;
    tsm_op_type     cmd_op;
    logic [2:0]     esz_code;
    logic [3:0]     cmd_tile;
    logic [1:0]     cmd_rs;
    logic [3:0]     cmd_off;
    logic           cmd_vert;
    logic [2:0]     cmd_pg;
    logic [1:0]     cmd_sel;
    tsm_status_type chk;
    logic           exec_ok;

    assign go       = wr_pend_q && (wr_addr_q == `TSM_OFF_CMD);
    assign cmd_op   = tsm_op_type'(hwdata[`TSM_F_OP +: 4]);
    assign esz_code = hwdata[`TSM_F_SIZE +: 3];
    assign cmd_tile = hwdata[`TSM_F_TILE +: 4];
    assign cmd_rs   = hwdata[`TSM_F_RS +: 2];
    assign cmd_off  = hwdata[`TSM_F_OFF +: 4];
    assign cmd_vert = hwdata[`TSM_F_VERT];
    assign cmd_pg   = hwdata[`TSM_F_PG +: 3];
    assign cmd_sel  = hwdata[`TSM_F_SEL +: 2];

    // Legality and enable checks; undefined wins over trap
    always_comb begin
        chk = ST_OK;
        case (cmd_op)
            OP_SLICE_MOVE: begin
                if (esz_code > `TSM_SIZE_MAX) begin
                    chk = ST_ILLEGAL;
                end else if (!ctrl_q[`TSM_CTRL_STREAM] || !ctrl_q[`TSM_CTRL_MATRIX]) begin
                    chk = ST_TRAP;
                end
            end
            OP_TABLE_READ, OP_TABLE_WRITE: begin
                if (!ctrl_q[`TSM_CTRL_V2] || !ctrl_q[`TSM_CTRL_HALTED]) begin
                    chk = ST_UNDEFINED;
                end else if (!ctrl_q[`TSM_CTRL_TABLE]) begin
                    chk = ST_TRAP;
                end
            end
            OP_EXPAND_ONE, OP_EXPAND_PAIR, OP_ALL_ACTIVE: begin
                if (!ctrl_q[`TSM_CTRL_V2]) begin
                    chk = ST_UNDEFINED;
                end else if (!ctrl_q[`TSM_CTRL_STREAM]) begin
                    chk = ST_TRAP;
                end
            end
            default: chk = ST_ILLEGAL;
        endcase
    end

    // one fixed cycle for every command
    assign exec_ok = go && (chk == ST_OK);

    // ****************************************
    // Slice move addressing
    // ****************************************
    logic [3:0]  tile_mask;
    logic [3:0]  dim_mask;
    logic [3:0]  tile_sel;
    logic [3:0]  off_sel;
    logic [3:0]  slice_idx;
    logic [3:0]  row_h;
    logic [15:0] gov_pred;

    // tiles = one shifted by size
    assign tile_mask = 4'((5'h01 << esz_code) - 5'h01);
    assign tile_sel  = cmd_tile & tile_mask;
    assign dim_mask  = 4'((5'h10 >> esz_code) - 5'h01);
    assign off_sel   = cmd_off & dim_mask;
    assign slice_idx = (w_q[cmd_rs][3:0] + off_sel) & dim_mask;
    assign row_h     = 4'(slice_idx << esz_code) + tile_sel;
    assign gov_pred  = pred_q[{1'b0, cmd_pg}];

    // Next matrix contents; untouched lanes fall through unchanged
    always_comb begin
        za_d = za_q;
        if (exec_ok && cmd_op == OP_SLICE_MOVE) begin
            for (int r = 0; r < `TSM_ZA_ROWS; r++) begin
                for (int b = 0; b < `TSM_VL; b++) begin
                    if (!cmd_vert) begin
                        if (4'(r) == row_h && pred_at(gov_pred, b / 8, esz_code)) begin
                            za_d[r][b] = vec_q[b];
                        end
                    end else if ((4'(r) & tile_mask) == tile_sel &&
                                 4'((b / 8) >> esz_code) == slice_idx &&
                                 pred_at(gov_pred, r, esz_code)) begin
                        za_d[r][b] = vec_q[((r >> esz_code) << (esz_code + 3))
                                           + (b % (8 << esz_code))];
                    end
                end
            end
        end
    end

    // Matrix array storage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int r = 0; r < `TSM_ZA_ROWS; r++) begin
                za_q[r] <= '0;
            end
        end else begin
            za_q <= za_d;
        end
    end

    // ****************************************
    // Lookup table and general register
    // ****************************************

    // byte offset is field times eight
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            zt_q <= '0;
        end else if (exec_ok && cmd_op == OP_TABLE_WRITE) begin
            zt_q[cmd_off[2:0]*64 +: 64] <= x_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            x_q <= '0;
        end else if (exec_ok && cmd_op == OP_TABLE_READ) begin
            x_q <= zt_q[cmd_off[2:0]*64 +: 64];
        end else if (wr_pend_q && wr_addr_q == `TSM_OFF_XLO) begin
            x_q[31:0] <= hwdata;
        end else if (wr_pend_q && wr_addr_q == `TSM_OFF_XHI) begin
            x_q[63:32] <= hwdata;
        end
    end

    // ****************************************
    // Predicate file
    // ****************************************
    logic [63:0] wide_mask;
    logic [15:0] keep_pat;
    logic [3:0]  pair_next;

    assign wide_mask = counter_to_mask(pred_q[{1'b1, cmd_pg}]);
    assign keep_pat  = low_pattern(esz_code[1:0]);
    assign pair_next = cmd_tile + 4'h1;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 16; i++) begin
                pred_q[i] <= '0;
            end
        end else if (exec_ok && cmd_op == OP_EXPAND_ONE) begin
            pred_q[cmd_tile] <= wide_mask[cmd_sel*16 +: 16] & keep_pat;
        end else if (exec_ok && cmd_op == OP_EXPAND_PAIR) begin
            pred_q[cmd_tile]  <= wide_mask[cmd_sel[0]*32 +: 16] & keep_pat;
            pred_q[pair_next] <= wide_mask[cmd_sel[0]*32 + 16 +: 16] & keep_pat;
        end else if (exec_ok && cmd_op == OP_ALL_ACTIVE) begin
            pred_q[{1'b1, cmd_pg}] <= all_active_code(esz_code[1:0]);
        end else if (wr_pend_q && wr_addr_q == `TSM_OFF_PDATA) begin
            pred_q[psel_q] <= hwdata[15:0];
        end
    end

    // ****************************************
    // Software registers
    // ****************************************

    // Control, selectors, slice base and vector operands
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= `TSM_CTRL_RESET;
            psel_q <= 4'h0;
            zsel_q <= 6'h00;
            tsel_q <= 4'h0;
            vec_q  <= '0;
            for (int i = 0; i < 4; i++) begin
                w_q[i] <= `TSM_WORD_RESET;
            end
        end else if (wr_pend_q) begin
            case (wr_addr_q)
                `TSM_OFF_CTRL: ctrl_q <= hwdata[`TSM_CTRL_WIDTH-1:0];
                `TSM_OFF_PSEL: psel_q <= hwdata[3:0];
                `TSM_OFF_ZSEL: zsel_q <= hwdata[5:0];
                `TSM_OFF_TSEL: tsel_q <= hwdata[3:0];
                default: begin
                    if (wr_addr_q[7:4] == `TSM_OFF_W_BASE >> 4) begin
                        w_q[wr_addr_q[3:2]] <= hwdata;
                    end else if (wr_addr_q[7:4] == `TSM_OFF_V_BASE >> 4) begin
                        vec_q[wr_addr_q[3:2]*32 +: 32] <= hwdata;
                    end
                end
            endcase
        end
    end

    // Last command, outcome and completion count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_cmd_q <= `TSM_WORD_RESET;
            status_q   <= ST_OK;
            done_cnt_q <= 16'h0000;
        end else if (go) begin
            last_cmd_q <= hwdata;
            status_q   <= chk;
            done_cnt_q <= done_cnt_q + 16'h0001;
        end
    end

endmodule : tsm_core

// [bench/tsm_core_monitor.sv]
// Purpose: Bus-level assertions for the slice, table and predicate engine
// Assumes: Status and echo reads are judged in their data phase
// Notes:   Bound to tsm_core after the module
`timescale 1ns/1ns
`include "tsm_defines.svh"
module tsm_core_monitor
    import tsm_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        hresp
);
    logic        dp_q;
    logic        dw_q;
    logic [7:0]  da_q;
    logic [5:0]  ctrl_q;
    logic [5:0]  cctl_q;
    logic [31:0] cmd_q;
    wire         rd_stat = dp_q && !dw_q && da_q == `TSM_OFF_STATUS;
    wire  [3:0]  op      = cmd_q[3:0];

    // Data phase tracking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_q <= 1'b0;
            dw_q <= 1'b0;
            da_q <= 8'h00;
        end else begin
            dp_q <= hsel && htrans[1] && hready;
            dw_q <= hwrite;
            da_q <= haddr[7:0];
        end
    end

    // Shadow of control and of the enables a command saw
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= 6'h00;
            cctl_q <= 6'h00;
            cmd_q  <= 32'h0000_0000;
        end else if (dp_q && dw_q) begin
            if (da_q == `TSM_OFF_CTRL) ctrl_q <= hwdata[5:0];
            if (da_q == `TSM_OFF_CMD) begin
                cmd_q  <= hwdata;
                cctl_q <= ctrl_q;
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    ready_always_a: assert property (hreadyout)
        else $error("wait state inserted");
    resp_okay_a: assert property (!hresp)
        else $error("error response seen");
    rdata_idle_a: assert property (!(dp_q && !dw_q) |-> hrdata == 32'h0)
        else $error("read data outside data phase");
    ctrl_echo_a: assert property (dp_q && !dw_q && da_q == `TSM_OFF_CTRL
        |-> hrdata[5:0] == ctrl_q) else $error("control readback wrong");
    table_undef_a: assert property (rd_stat && op[3:1] == 3'h1
        && !(cctl_q[3] && cctl_q[4]) |-> hrdata[1:0] == 2'h1)
        else $error("table move not undefined");
    trap_off_a: assert property (rd_stat && op == 4'h1 && !cctl_q[0]
        |-> hrdata[1:0] == (cmd_q[6:4] > 3'h4 ? 2'h3 : 2'h2)) else $error("missing trap");
    bad_size_a: assert property (rd_stat && op == 4'h1 && cctl_q[1:0] == 2'h3
        && cmd_q[6:4] > 3'h4 |-> hrdata[1:0] == 2'h3) else $error("bad size accepted");
    cmd_echo_a: assert property (dp_q && !dw_q && da_q == `TSM_OFF_CMD
        |-> hrdata == cmd_q) else $error("command readback wrong");
    all_ok_a: assert property (rd_stat && op == 4'h6 && cctl_q[0] && cctl_q[4]
        |-> hrdata[1:0] == 2'h0) else $error("all-active refused");

    // Main scenarios reached
    cover property (rd_stat && op == 4'h3 && cctl_q[4:3] == 2'h3);
    cover property (rd_stat && op == 4'h1 && !cctl_q[0]);
    cover property (rd_stat && op == 4'h5);
endmodule : tsm_core_monitor

bind tsm_core tsm_core_monitor mon (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp)
);

// [bench/tsm_pipe_model.sv]
// Purpose: Pipeline side issuing single-word register transfers
// Assumes: One transfer at a time, slave may stretch either phase
// Notes:   The bench calls write_word and read_word by hierarchy
`timescale 1ns/1ns
module tsm_pipe_model (
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    // Idle bus from time zero
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0000_0000;
    end

    // Address phase held until ready is sampled
    task automatic issue(input logic [7:0] a, input logic wr);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
    endtask : issue

    // Stale data inverted so a late sample cannot match
    task automatic write_word(input logic [7:0] a, input logic [31:0] d);
        issue(a, 1'b1);
        hwdata <= d;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        hwdata <= ~d;
    endtask : write_word

    task automatic read_word(input logic [7:0] a, output logic [31:0] d);
        issue(a, 1'b0);
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        d = hrdata;
    endtask : read_word
endmodule : tsm_pipe_model

// [bench/tile_slice_move_and_predicate_ops_bench.sv]
// Purpose: Self-checking bench for the slice, table and predicate engine
// Assumes: Control value 6'h3f enables every feature
// Notes:   Expected values worked out by hand from the field layout
`timescale 1ns/1ns
`include "tsm_defines.svh"
module tile_slice_move_and_predicate_ops_bench
    import tsm_pkg::*;
;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic [31:0] rd;
    int          fail_count = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    always #5 hclk = ~hclk;

    tsm_core dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp)
    );
    tsm_pipe_model pipe (
        .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
    );

    // ****************************************
    // Bus and compare helpers
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        pipe.write_word(a, d);
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string w);
        pipe.read_word(a, rd);
        check(w, rd, e);
    endtask : rc

    // Issue a command and compare the outcome code only
    task automatic st(input logic [31:0] c, input logic [1:0] e);
        wr(`TSM_OFF_CMD, c);
        pipe.read_word(`TSM_OFF_STATUS, rd);
        check("status", {30'h0, rd[1:0]}, {30'h0, e});
    endtask : st

    function automatic logic [31:0] cmd(input tsm_op_type op, input int sz, t, ws, off,
                                        input int v, pg, sel);
        return 32'(op) | 32'(sz) << `TSM_F_SIZE | 32'(t) << `TSM_F_TILE
             | 32'(ws) << `TSM_F_RS | 32'(off) << `TSM_F_OFF | 32'(v) << `TSM_F_VERT
             | 32'(pg) << `TSM_F_PG | 32'(sel) << `TSM_F_SEL;
    endfunction : cmd

    // Predicate P3, source vector b..b+3, then the move
    task automatic mv(input logic [31:0] p, input logic [31:0] b, input logic [31:0] c);
        wr(`TSM_OFF_PDATA, p);
        for (int i = 0; i < 4; i++) wr(`TSM_OFF_V_BASE + 8'(4 * i), b + i);
        st(c, 2'h0);
    endtask : mv

    task automatic zc(input int r, input int w, input logic [31:0] e);
        wr(`TSM_OFF_ZSEL, 32'(r * 4 + w));
        rc(`TSM_OFF_ZDATA, e, "matrix word");
    endtask : zc

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    // Hang guard, far above the few hundred cycles needed
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            summarize();
        end
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rc(`TSM_OFF_CTRL, 32'h0, "ctrl reset");
        wr(8'hfc, 32'hffff_ffff);
        rc(8'hfc, 32'h0, "unmapped");
        $display("test reset done");
        // Refused commands change nothing
        wr(`TSM_OFF_XLO, 32'h5555_5555);
        wr(`TSM_OFF_CTRL, 32'h07);
        st(cmd(OP_TABLE_WRITE, 0, 0, 0, 1, 0, 0, 0), 2'h1);
        wr(`TSM_OFF_CTRL, 32'h0f);
        st(cmd(OP_TABLE_READ, 0, 0, 0, 1, 0, 0, 0), 2'h1);
        wr(`TSM_OFF_CTRL, 32'h3b);
        st(cmd(OP_TABLE_WRITE, 0, 0, 0, 1, 0, 0, 0), 2'h2);
        wr(`TSM_OFF_CTRL, 32'h3e);
        st(cmd(OP_SLICE_MOVE, 2, 0, 0, 0, 0, 0, 0), 2'h2);
        wr(`TSM_OFF_CTRL, 32'h3f);
        st(cmd(OP_SLICE_MOVE, 5, 0, 0, 0, 0, 0, 0), 2'h3);
        wr(`TSM_OFF_TSEL, 32'h2);
        rc(`TSM_OFF_TDATA, 32'h0, "table untouched");
        $display("test refusal done");
        // Every doubleword of the table, then one read back
        for (int k = 0; k < 8; k++) begin
            wr(`TSM_OFF_XLO, 32'ha000_0000 + k);
            wr(`TSM_OFF_XHI, 32'hb000_0000 + k);
            st(cmd(OP_TABLE_WRITE, 0, 0, 0, k, 0, 0, 0), 2'h0);
        end
        for (int w = 0; w < 16; w++) begin
            wr(`TSM_OFF_TSEL, 32'(w));
            rc(`TSM_OFF_TDATA, (w % 2 ? 32'hb000_0000 : 32'ha000_0000) + w / 2, "tw");
        end
        wr(`TSM_OFF_XLO, 32'h0);
        wr(`TSM_OFF_XHI, 32'h0);
        st(cmd(OP_TABLE_READ, 0, 0, 0, 5, 0, 0, 0), 2'h0);
        rc(`TSM_OFF_XLO, 32'ha000_0005, "x low");
        rc(`TSM_OFF_XHI, 32'hb000_0005, "x high");
        $display("test table done");
        // Slices: W13 = 5, W14 = 3, governing predicate P3
        wr(`TSM_OFF_W_BASE + 8'h4, 32'h5);
        wr(`TSM_OFF_W_BASE + 8'h8, 32'h3);
        wr(`TSM_OFF_PSEL, 32'h3);
        mv(32'hffff, 32'ha0, cmd(OP_SLICE_MOVE, 2, 1, 1, 2, 0, 3, 0));
        mv(32'h0101, 32'hb0, cmd(OP_SLICE_MOVE, 2, 1, 1, 2, 0, 3, 0));
        for (int w = 0; w < 4; w++) zc(13, w, (w % 2 ? 32'ha0 : 32'hb0) + w);
        mv(32'hffff, 32'hc0, cmd(OP_SLICE_MOVE, 2, 1, 1, 2, 1, 3, 0));
        for (int k = 0; k < 4; k++) zc(4 * k + 1, 3, 32'hc0 + k);
        mv(32'hffff, 32'hd0, cmd(OP_SLICE_MOVE, 3, 5, 1, 1, 0, 3, 0));
        for (int w = 0; w < 4; w++) zc(5, w, 32'hd0 + w);
        mv(32'h00f0, 32'he0, cmd(OP_SLICE_MOVE, 0, 0, 2, 15, 0, 3, 0));
        zc(2, 1, 32'he1);
        zc(2, 0, 32'h0);
        mv(32'hffff, 32'hf0, cmd(OP_SLICE_MOVE, 4, 9, 1, 3, 0, 3, 0));
        zc(9, 2, 32'hf2);
        $display("test slice done");
        // Counter of 20 bytes in PN9, quarters copied out
        wr(`TSM_OFF_PSEL, 32'h9);
        wr(`TSM_OFF_PDATA, 32'h29);
        st(cmd(OP_EXPAND_ONE, 0, 2, 0, 0, 0, 1, 1), 2'h0);
        wr(`TSM_OFF_PSEL, 32'h2);
        rc(`TSM_OFF_PDATA, 32'h000f, "quarter one");
        st(cmd(OP_EXPAND_PAIR, 0, 15, 0, 0, 0, 1, 0), 2'h0);
        wr(`TSM_OFF_PSEL, 32'hf);
        rc(`TSM_OFF_PDATA, 32'hffff, "pair first");
        wr(`TSM_OFF_PSEL, 32'h0);
        rc(`TSM_OFF_PDATA, 32'h000f, "pair second");
        wr(`TSM_OFF_PSEL, 32'h9);
        wr(`TSM_OFF_PDATA, 32'h2a);
        st(cmd(OP_EXPAND_ONE, 1, 4, 0, 0, 0, 1, 1), 2'h0);
        wr(`TSM_OFF_PSEL, 32'h4);
        rc(`TSM_OFF_PDATA, 32'h0005, "halfword expand");
        // All-active for every size code
        for (int s = 0; s < 4; s++) begin
            st(cmd(OP_ALL_ACTIVE, s, 0, 0, 0, 0, s, 0), 2'h0);
            wr(`TSM_OFF_PSEL, 32'(8 + s));
            rc(`TSM_OFF_PDATA, 32'h20 | (32'h1 << s), "all active");
        end
        $display("test predicate done");
        summarize();
    end
endmodule : tile_slice_move_and_predicate_ops_bench
